// [hdl/rfc_regs.sv]
// Front end and synthesizer calibration register bank with the
// transmit amplifier level sequencer.
// Assumes register strobes, transmit symbol and burst levels and the
// calibration engine outputs are all synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none

module rfc_regs
   import rfc_pkg::*;
#(
   parameter int unsigned RAMP_STEP = RAMP_STEP_CYC
) (
   // Clock and reset.
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   // Register port from the host port core.
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [ADDR_W-1:0]            reg_addr,
   input  wire logic [DATA_W-1:0]            reg_wdata,
   output logic      [DATA_W-1:0]            reg_rdata,
   // Amplifier setting table contents, entry i at bits [8*i+7:8*i].
   input  wire logic [TABLE_DEPTH*DATA_W-1:0] amp_setting_table,
   // Transmit control.
   input  wire logic                         tx_active,
   input  wire logic                         tx_keyed_mode,
   input  wire logic                         tx_symbol,
   output logic      [DATA_W-1:0]            amp_setting,
   output logic      [LEVEL_W-1:0]           amp_entry,
   // Synthesizer calibration engine.
   input  wire logic                         cal_done,
   input  wire logic [3:0]                   cal_pump_code,
   input  wire logic [4:0]                   cal_vco_code,
   output logic                              pump_cal_stage_run,
   output logic      [1:0]                   synth_cal_config,
   output logic      [3:0]                   pump_current_code,
   output logic      [4:0]                   vco_current_code,
   output logic                              oscillator_core_high_select,
   // Receive and transmit front end trims.
   output logic      [7:0]                   rx_front_end_trim,
   output logic      [1:0]                   tx_lo_buffer_trim
);

   typedef struct packed {
      logic [7:0]            rx_trim;
      logic [1:0]            tx_lo;
      logic [LEVEL_W-1:0]    tx_level_index;
      logic [1:0]            cal_cfg;
      logic [1:0]            pump_en;
      logic [3:0]            pump_code;
      logic                  core_hi;
      logic [4:0]            vco_code;
      logic [LEVEL_W-1:0]    step;
      rfc_ramp_t             ramp;
      logic [RAMP_TMR_W-1:0] tmr;
      logic [DATA_W-1:0]     rdata;
      logic [DATA_W-1:0]     amp;
   } rfc_state_t;

   rfc_state_t s_q;
   rfc_state_t s_d;

   // Shared write decode for one register offset.
   function automatic logic wr_hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
      wr_hit = (a == ofs);
   endfunction

   // Picks one entry of the amplifier setting table.
   function automatic logic [DATA_W-1:0] table_entry(
      input logic [TABLE_DEPTH*DATA_W-1:0] tbl,
      input logic [LEVEL_W-1:0]            idx);
      table_entry = tbl[idx*DATA_W +: DATA_W];
   endfunction

   logic [LEVEL_W-1:0] target;

   always_comb begin
      s_d = s_q;
      // Where the sequencer is heading: keyed zero rests on entry zero,
      // everything else on the chosen level; outside a burst it falls back.
      if (!tx_active) begin
         target = '0;
      end else if (tx_keyed_mode && !tx_symbol) begin
         target = '0;
      end else begin
         target = s_q.tx_level_index;
      end

      // Register writes. Reserved bits are simply not stored.
      if (reg_wr) begin
         if (wr_hit(reg_addr, RX_FRONT_END_TRIM_OFS)) begin
            s_d.rx_trim = reg_wdata;
         end
         if (wr_hit(reg_addr, TX_FRONT_END_CONFIG_OFS)) begin
            s_d.tx_lo          = reg_wdata[TX_LO_BUFFER_TRIM_POS +: 2];
            s_d.tx_level_index = reg_wdata[TX_LEVEL_INDEX_POS +: LEVEL_W];
         end
         if (wr_hit(reg_addr, SYNTH_CAL_PUMP_RESULT_OFS)) begin
            s_d.cal_cfg   = reg_wdata[SYNTH_CAL_CONFIG_POS +: 2];
            s_d.pump_en   = reg_wdata[PUMP_CAL_STAGE_ENABLE_POS +: 2];
            s_d.pump_code = reg_wdata[PUMP_CODE_POS +: 4];
         end
         if (wr_hit(reg_addr, SYNTH_CAL_VCO_RESULT_OFS)) begin
            s_d.core_hi  = reg_wdata[CORE_HIGH_SELECT_POS];
            s_d.vco_code = reg_wdata[VCO_CODE_POS +: 5];
         end
      end

      // A finished calibration wins over a write in the same cycle, so
      // the freshly found codes are never lost. The pump code only moves
      // when its stage actually ran.
      if (cal_done) begin
         s_d.vco_code = cal_vco_code;
         if (s_q.pump_en == PUMP_CAL_STAGE_ON) begin
            s_d.pump_code = cal_pump_code;
         end
      end

      // Register reads, answered one cycle after the strobe.
      if (reg_rd) begin
         case (reg_addr)
            RX_FRONT_END_TRIM_OFS: begin
               s_d.rdata = s_q.rx_trim;
            end
            TX_FRONT_END_CONFIG_OFS: begin
               s_d.rdata = {2'h0, s_q.tx_lo, 1'b0, s_q.tx_level_index};
            end
            SYNTH_CAL_PUMP_RESULT_OFS: begin
               s_d.rdata = {s_q.cal_cfg, s_q.pump_en, s_q.pump_code};
            end
            SYNTH_CAL_VCO_RESULT_OFS: begin
               s_d.rdata = {2'h0, s_q.core_hi, s_q.vco_code};
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end

      // Level sequencer: one table entry per step period, walking through
      // every entry between zero and the target rather than jumping, which
      // keeps the spectrum clean at burst edges and keyed transitions.
      case (s_q.ramp)
         RFC_HOLD: begin
            s_d.tmr = '0;
            if (target > s_q.step) begin
               s_d.ramp = RFC_UP;
            end else if (target < s_q.step) begin
               s_d.ramp = RFC_DOWN;
            end
         end
         RFC_UP, RFC_DOWN: begin
            if (s_q.tmr >= RAMP_TMR_W'(RAMP_STEP - 1)) begin
               s_d.tmr = '0;
               if (target > s_q.step) begin
                  s_d.step = s_q.step + 3'h1;
               end else if (target < s_q.step) begin
                  s_d.step = s_q.step - 3'h1;
               end
               if (target == s_d.step) begin
                  s_d.ramp = RFC_HOLD;
               end else if (target > s_d.step) begin
                  s_d.ramp = RFC_UP;
               end else begin
                  s_d.ramp = RFC_DOWN;
               end
            end else begin
               s_d.tmr = s_q.tmr + 12'h001;
            end
         end
         default: begin
            s_d.ramp = RFC_HOLD;
            s_d.tmr  = '0;
         end
      endcase

      s_d.amp = table_entry(amp_setting_table, s_d.step);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q.rx_trim        <= RX_FRONT_END_TRIM_RST;
         s_q.tx_lo          <= TX_LO_BUFFER_TRIM_RST;
         s_q.tx_level_index <= TX_LEVEL_INDEX_RST;
         s_q.cal_cfg        <= SYNTH_CAL_CONFIG_RST;
         s_q.pump_en        <= PUMP_CAL_STAGE_ENABLE_RST;
         s_q.pump_code      <= PUMP_CODE_RST;
         s_q.core_hi        <= CORE_HIGH_SELECT_RST;
         s_q.vco_code       <= VCO_CODE_RST;
         s_q.step           <= '0;
         s_q.ramp           <= RFC_HOLD;
         s_q.tmr            <= '0;
         s_q.rdata          <= 8'h00;
         s_q.amp            <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata                   = s_q.rdata;
   assign amp_setting                 = s_q.amp;
   assign amp_entry                   = s_q.step;
   assign pump_cal_stage_run          = (s_q.pump_en == PUMP_CAL_STAGE_ON);
   assign synth_cal_config            = s_q.cal_cfg;
   assign pump_current_code           = s_q.pump_code;
   assign vco_current_code            = s_q.vco_code;
   assign oscillator_core_high_select = s_q.core_hi;
   assign rx_front_end_trim           = s_q.rx_trim;
   assign tx_lo_buffer_trim           = s_q.tx_lo;

endmodule

`default_nettype wire

// [shared/rfc_pkg.sv]
// Constants, register map and types for the front end and synthesizer
// calibration register bank.
// Assumes a host port core that turns serial transfers into
// single-cycle register read and write strobes.
//
// Contract
// - Level index points into eight-entry amplifier table.
// - Keyed one symbol uses the indexed entry.
// - Keyed zero symbol uses table entry zero.
// - Step entries zero to index for shaping, ramps.
// - Pump calibration stage runs only when enable is one.
// - Pump code is four bits, resets to 1001.
// - Rewritten calibration results are used directly for hopping.
// - Core select one picks high core, zero low.
// - Five-bit oscillator current code, reset 0x0A, writable override.
package rfc_pkg;

   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned TABLE_DEPTH = 8;
   localparam int unsigned LEVEL_W = 3;

   // Register offsets.
   localparam logic [5:0] RX_FRONT_END_TRIM_OFS     = 6'h21;
   localparam logic [5:0] TX_FRONT_END_CONFIG_OFS   = 6'h22;
   localparam logic [5:0] SYNTH_CAL_PUMP_RESULT_OFS = 6'h23;
   localparam logic [5:0] SYNTH_CAL_VCO_RESULT_OFS  = 6'h24;

   // Field positions (low bit of each field).
   localparam int unsigned TX_LO_BUFFER_TRIM_POS     = 4;
   localparam int unsigned TX_LEVEL_INDEX_POS        = 0;
   localparam int unsigned SYNTH_CAL_CONFIG_POS      = 6;
   localparam int unsigned PUMP_CAL_STAGE_ENABLE_POS = 4;
   localparam int unsigned PUMP_CODE_POS             = 0;
   localparam int unsigned CORE_HIGH_SELECT_POS      = 5;
   localparam int unsigned VCO_CODE_POS              = 0;

   // Reset values.
   localparam logic [7:0] RX_FRONT_END_TRIM_RST     = 8'h56;
   localparam logic [1:0] TX_LO_BUFFER_TRIM_RST     = 2'h1;
   localparam logic [2:0] TX_LEVEL_INDEX_RST        = 3'h0;
   localparam logic [1:0] SYNTH_CAL_CONFIG_RST      = 2'h2;
   localparam logic [1:0] PUMP_CAL_STAGE_ENABLE_RST = 2'h2;
   localparam logic [3:0] PUMP_CODE_RST             = 4'h9;
   localparam logic       CORE_HIGH_SELECT_RST      = 1'b0;
   localparam logic [4:0] VCO_CODE_RST              = 5'h0A;

   // Enable value that runs the pump calibration stage.
   localparam logic [1:0] PUMP_CAL_STAGE_ON = 2'h1;

   // Power ramp timing: dwell on each table entry while ramping.
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned RAMP_STEP_NS   = 1000;
   localparam int unsigned RAMP_STEP_CYC  =
      (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RAMP_TMR_W     = 12;

   typedef enum logic [1:0] {
      RFC_HOLD = 2'b00,
      RFC_UP   = 2'b01,
      RFC_DOWN = 2'b11
   } rfc_ramp_t;

endpackage

// [sim/rfc_regs_properties.sv]
// Port checker for the calibration register bank.
// Assumes RAMP_STEP of two or more cycles and a table held still.
`timescale 1ns/10ps
`default_nettype none
module rfc_regs_properties
   import rfc_pkg::*;
#(
   parameter int unsigned RAMP_STEP = 2
) (
   // Clock, reset and register port.
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [ADDR_W-1:0]             reg_addr,
   input  wire logic [DATA_W-1:0]             reg_wdata,
   input  wire logic [DATA_W-1:0]             reg_rdata,
   // Transmit sequencer.
   input  wire logic [TABLE_DEPTH*DATA_W-1:0] amp_setting_table,
   input  wire logic [DATA_W-1:0]             amp_setting,
   input  wire logic [LEVEL_W-1:0]            amp_entry,
   input  wire logic                          tx_active,
   input  wire logic                          tx_keyed_mode,
   input  wire logic                          tx_symbol,
   // Calibration.
   input  wire logic                          cal_done,
   input  wire logic                          pump_cal_stage_run,
   input  wire logic                          oscillator_core_high_select,
   input  wire logic [3:0]                    cal_pump_code,
   input  wire logic [3:0]                    pump_current_code,
   input  wire logic [4:0]                    cal_vco_code,
   input  wire logic [4:0]                    vco_current_code
);
   logic [DATA_W-1:0]  wdata_q;
   logic [LEVEL_W-1:0] entry_q;
   logic [11:0]        gap_q;
   // Cycles since the sequencer last moved, held at its ceiling so a long
   // idle stretch cannot wrap back to a small count.
   always_ff @(posedge ref_clk) begin
      wdata_q <= reg_wdata;
      entry_q <= amp_entry;
      if (!rst_n || amp_entry != entry_q) begin
         gap_q <= 12'h000;
      end else if (gap_q != 12'hFFF) begin
         gap_q <= gap_q + 12'h001;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   unmap_read_a: assert property (reg_rd && !(reg_addr inside {[6'h21:6'h24]})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   rsv_read_a: assert property (reg_rd && reg_addr == 6'h22
      |=> (reg_rdata & 8'hC8) == 8'h00) else $error("reserved bits not zero");
   pump_run_a: assert property (reg_rd && reg_addr == 6'h23
      |=> (reg_rdata[5:4] == 2'h1) == $past(pump_cal_stage_run)) else $error("pump run decode");
   cal_vco_a: assert property (cal_done
      |=> vco_current_code == $past(cal_vco_code)) else $error("vco code not loaded");
   cal_pump_a: assert property (cal_done && pump_cal_stage_run
      |=> pump_current_code == $past(cal_pump_code)) else $error("pump code not loaded");
   pump_hold_a: assert property (cal_done && !pump_cal_stage_run && !reg_wr
      |=> $stable(pump_current_code)) else $error("pump code moved");
   vco_write_a: assert property (reg_wr && reg_addr == 6'h24 && !cal_done
      |=> vco_current_code == wdata_q[4:0] && oscillator_core_high_select == wdata_q[5])
      else $error("vco write lost");
   amp_map_a: assert property ($past(rst_n) && $stable(amp_setting_table)
      |-> amp_setting == amp_setting_table[amp_entry*8 +: 8]) else $error("table entry wrong");
   step_one_a: assert property ($past(rst_n) && $changed(amp_entry)
      |-> amp_entry == $past(amp_entry) + 3'h1 || amp_entry == $past(amp_entry) - 3'h1)
      else $error("ramp skipped an entry");
   ramp_pace_a: assert property ($changed(amp_entry) |=> $stable(amp_entry))
      else $error("ramp too fast");
   ramp_gap_a: assert property ($past(rst_n) && $changed(amp_entry)
      |-> gap_q >= RAMP_STEP - 1) else $error("ramp step too short");
   zero_sym_a: assert property ($past(rst_n) && amp_entry > $past(amp_entry)
      |-> $past(tx_active) && !($past(tx_keyed_mode) && !$past(tx_symbol)))
      else $error("ramp rose without a one symbol");
   cover property (cal_done && pump_cal_stage_run);
   cover property (amp_entry == 3'h5 && tx_keyed_mode);
   cover property (reg_rd && reg_addr == 6'h25);
endmodule
bind rfc_regs rfc_regs_properties #(.RAMP_STEP(RAMP_STEP)) chk_u (.*);
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the calibration register bank.
// Assumes the package and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module testbench
   import rfc_pkg::*;
;
   logic        ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cal_done = 0;
   logic        tx_active = 0, tx_keyed_mode = 0, tx_symbol = 0;
   logic        pump_cal_stage_run, oscillator_core_high_select;
   logic [5:0]  reg_addr = 6'h00;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata, amp_setting, rx_front_end_trim, rd_v;
   logic [63:0] amp_setting_table = 64'h8786858483828180;
   logic [2:0]  amp_entry;
   logic [3:0]  cal_pump_code = 4'h0, pump_current_code;
   logic [4:0]  cal_vco_code = 5'h00, vco_current_code;
   logic [1:0]  synth_cal_config, tx_lo_buffer_trim;
   logic [7:0]  rst_v [4] = '{8'h56, 8'h10, 8'hA9, 8'h0A};
   // Address, write data, expected read back.
   logic [21:0] rows [6] = '{{6'h21, 8'hA5, 8'hA5}, {6'h22, 8'hFF, 8'h37},
      {6'h23, 8'hD6, 8'hD6}, {6'h24, 8'hFF, 8'h3F}, {6'h25, 8'h77, 8'h00},
      {6'h20, 8'h11, 8'h00}};
   int          error_cnt = 0, tests_run = 0, cyc = 0;
   rfc_regs #(.RAMP_STEP(2)) dut_u (.*);
   always #25 ref_clk = ~ref_clk;
   // A hang is cut short well past the roughly 150 cycles the run needs.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rd_v = reg_rdata;
   endtask
   task automatic cal(input logic [3:0] p, input logic [4:0] v);
      @(posedge ref_clk);
      cal_done <= 1'b1;
      cal_pump_code <= p;
      cal_vco_code <= v;
      @(posedge ref_clk);
      cal_done <= 1'b0;
      @(negedge ref_clk);
   endtask
   // Sixteen cycles cover a full five-step ramp at two cycles a step.
   task automatic tx(input logic a, input logic k, input logic s);
      @(posedge ref_clk);
      tx_active <= a;
      tx_keyed_mode <= k;
      tx_symbol <= s;
      repeat (16) @(negedge ref_clk);
   endtask
   task automatic report_and_stop();
      $display("Checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(6'(33 + i));
         `CHK(rd_v, rst_v[i])
      end
      for (int i = 0; i < 6; i++) begin
         wr(rows[i][21:16], rows[i][15:8]);
         rd(rows[i][21:16]);
         `CHK(rd_v, rows[i][7:0])
      end
      `CHK(rx_front_end_trim, 8'hA5)
      `CHK(tx_lo_buffer_trim, 2'h3)
      `CHK(synth_cal_config, 2'h3)
      for (int e = 0; e < 4; e++) begin
         wr(6'h23, {2'h2, 2'(e), 4'hC});
         `CHK(synth_cal_config, 2'h2)
         `CHK(pump_cal_stage_run, (e == 1))
         cal(4'h3, 5'(e + 5'h1B));
         `CHK(pump_current_code, (e == 1) ? 4'h3 : 4'hC)
         `CHK(vco_current_code, 5'(e + 5'h1B))
      end
      wr(6'h23, 8'h95);
      `CHK(pump_current_code, 4'h5)
      wr(6'h24, 8'h35);
      `CHK(oscillator_core_high_select, 1'b1)
      `CHK(vco_current_code, 5'h15)
      wr(6'h24, 8'h0A);
      `CHK(oscillator_core_high_select, 1'b0)
      wr(6'h22, 8'h15);
      tx(1'b1, 1'b0, 1'b0);
      `CHK(amp_entry, 3'h5)
      `CHK(amp_setting, 8'h85)
      tx(1'b1, 1'b1, 1'b0);
      `CHK(amp_setting, 8'h80)
      tx(1'b1, 1'b1, 1'b1);
      `CHK(amp_entry, 3'h5)
      tx(1'b0, 1'b1, 1'b1);
      `CHK(amp_entry, 3'h0)
      tx(1'b1, 1'b0, 1'b0);
      `CHK(amp_entry, 3'h5)
      // A reset in mid-burst must drop the sequencer and every register.
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      `CHK(amp_entry, 3'h0)
      `CHK(pump_current_code, PUMP_CODE_RST)
      `CHK(vco_current_code, VCO_CODE_RST)
      `CHK(oscillator_core_high_select, CORE_HIGH_SELECT_RST)
      `CHK(synth_cal_config, SYNTH_CAL_CONFIG_RST)
      for (int i = 0; i < 4; i++) begin
         rd(6'(33 + i));
         `CHK(rd_v, rst_v[i])
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
